// ===== verilog/rss_sequencer.sv
/*
  Reference search sequencer: homes one stepper axis against end switches,
  a home switch or an encoder index pulse, sets the zero point and reports
  the switch distance. Registers over APB, zero wait states.
  Assumes a motion controller that follows RUN/DIR/VEL and reports the
  actual position, and switch inputs synchronous to CLK_I.
*/
// The register addresses and register access over APB are this design's own decisions.
// Function
// - Opcode 13 command starts, stops, queries sequencer
// - End-switch auto stop settings never affect homing
// - Search velocity until zero switch or index detection
// - Creep off, re-enter, zero at middle
// - Calibration moves use creep velocity
// - Mode register selects base modes 1 to 10
// - Mode 1 left switch, 65 right switch
// - Mode 2 right then left, report distance
// - Mode 66 left first, right is zero
// - Mode 3 right, then left middle, distance
// - Mode 67 mirrors mode 3
// - Mode 4/68 middle of single end switch
// - Mode 5 home negative, reverse at left
// - Mode 6 home positive, reverse at right
// - Plus 128 inverts home switch polarity
// - Mode 7 home negative, no limits, middle
// - Mode 8 home positive, no limits, middle
// - Modes 9/10 index pulse positive/negative
// - Completion clears encoder position to zero
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int POS_W = 32
) (
  input  wire logic             CLK_I,
  input  wire logic             NRST_I,
  // APB slave
  input  wire logic             PSEL_I,
  input  wire logic             PENABLE_I,
  input  wire logic             PWRITE_I,
  input  wire logic [7:0]       PADDR_I,
  input  wire logic [31:0]      PWDATA_I,
  output logic      [31:0]      PRDATA_O,
  output logic                  PREADY_O,
  output logic                  PSLVERR_O,
  // Switches and encoder
  input  wire logic             LEFT_I,
  input  wire logic             RIGHT_I,
  input  wire logic             HOME_I,
  input  wire logic             INDEX_I,
  input  wire logic [POS_W-1:0] POS_I,
  input  wire logic [31:0]      ENC_CNT_I,
  // Motion request
  output logic                  RUN_O,
  output logic                  DIR_O,
  output logic      [31:0]      VEL_O,
  output logic                  ZERO_STB_O,
  output logic      [POS_W-1:0] ZERO_POS_O,
  output logic                  BUSY_O
);
  import rss_pkg::*;

  // Register file
  logic [7:0]       mode_reg, run_mode_reg;
  logic [31:0]      vsrch_reg, vcreep_reg, dist_reg, enc_ofs_reg, prdata_reg;
  logic [1:0]       stopcfg_reg;
  logic             done_reg, err_reg;
  // Sequencer
  rss_state_t       state_reg, state_next;
  rss_sw_t          sel_reg, sel_next;
  logic             dir_reg, dir_next;
  logic             run_reg, vel_fast_reg;
  logic             first_reg, first_next;
  logic [POS_W-1:0] a_reg, a_next, far_reg, far_next;
  logic             zstb_reg;
  logic [POS_W-1:0] zpos_reg;
  logic             fin_now;
  logic [POS_W-1:0] mid_pos;

  // Sign-extended midpoint of two switching points
  function automatic logic [POS_W-1:0] midpoint(input logic [POS_W-1:0] p, input logic [POS_W-1:0] q);
    logic [POS_W:0] s;
    s = {p[POS_W-1], p} + {q[POS_W-1], q};
    return s[POS_W:1];
  endfunction

  // Absolute distance between two positions
  function automatic logic [31:0] distance(input logic [POS_W-1:0] p, input logic [POS_W-1:0] q);
    logic [POS_W-1:0] d;
    d = p - q;
    if (d[POS_W-1]) begin
      d = q - p;
    end
    return 32'(d);
  endfunction

  // APB decode
  wire        wr_en     = PSEL_I & PENABLE_I & PWRITE_I;
  wire        rd_setup  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  wire        addr_hit  = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= RSS_OFS_STOPCFG);
  wire        wr_cmd    = wr_en && (PADDR_I == RSS_OFS_CMD);
  wire        cmd_ok    = wr_cmd && (PWDATA_I[RSS_CMD_OP_LSB +: 8] == RSS_OPCODE);
  wire [1:0]  cmd_act   = PWDATA_I[RSS_CMD_ACT_LSB +: 2];
  wire        idle      = (state_reg == RSS_S_IDLE);
  wire        cmd_start = cmd_ok && (cmd_act == RSS_ACT_START) && idle;
  wire        cmd_stop  = cmd_ok && (cmd_act == RSS_ACT_STOP);
  wire [31:0] enc_pos   = ENC_CNT_I - enc_ofs_reg;

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;

  // Mode decode of the latest written mode, checked at start
  wire [5:0] new_base  = mode_reg[5:0];
  wire       new_valid = (new_base != 6'h00) && (new_base <= RSS_MODE_BASE_MAX)
                         && !(mode_reg[RSS_MODE_SWAP_BIT] && new_base > 6'h04)
                         && !(mode_reg[RSS_MODE_INV_BIT] && (new_base < 6'h05 || new_base > 6'h08));

  // Mode decode of the run in progress
  wire [5:0] base    = run_mode_reg[5:0];
  wire       swap    = run_mode_reg[RSS_MODE_SWAP_BIT];
  wire       inv     = run_mode_reg[RSS_MODE_INV_BIT];
  wire       two_sw  = (base == 6'h02) || (base == 6'h03);
  wire       both    = (base == 6'h03) || (base == 6'h04) || (base == 6'h07) || (base == 6'h08);
  wire       homing  = (base >= 6'h05) && (base <= 6'h08);
  wire       indexed = (base == 6'h09) || (base == 6'h0A);
  wire       lim_rev = (base == 6'h05) || (base == 6'h06);

  // Start targets: the zero switch is left unless swapped; two-switch modes go far first
  wire       zero_right = swap;
  rss_sw_t   start_sel;
  logic      start_dir;
  assign start_sel = indexed ? RSS_SW_INDEX :
                     homing  ? RSS_SW_HOME :
                     (two_sw ^ zero_right) ? RSS_SW_RIGHT : RSS_SW_LEFT;
  assign start_dir = (base == 6'h09) ? 1'b1 : (base == 6'h0A) ? 1'b0 :
                     (base == 6'h06 || base == 6'h08) ? 1'b1 :
                     (base == 6'h05 || base == 6'h07) ? 1'b0 :
                     (start_sel == RSS_SW_RIGHT);

  // First leg's switch and direction, taken from the latched run mode
  rss_sw_t first_sel;
  logic    first_dir;
  logic    first_leg_far;
  assign first_sel     = start_sel;
  assign first_dir     = start_dir;
  assign first_leg_far = two_sw;

  // Switch levels; auto stop settings are not consulted here
  wire home_act = HOME_I ^ inv;
  wire sw_act   = (sel_reg == RSS_SW_LEFT)  ? LEFT_I :
                  (sel_reg == RSS_SW_RIGHT) ? RIGHT_I :
                  (sel_reg == RSS_SW_HOME)  ? home_act : INDEX_I;
  wire lim_hit  = lim_rev && (dir_reg ? RIGHT_I : LEFT_I);
  wire [POS_W-1:0] pos = POS_I;

  assign mid_pos = midpoint(a_reg, pos);

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    sel_next   = sel_reg;
    dir_next   = dir_reg;
    first_next = first_reg;
    a_next     = a_reg;
    far_next   = far_reg;
    fin_now    = 1'b0;
    case (state_reg)
      RSS_S_IDLE: begin
        state_next = state_reg;
      end
      RSS_S_FAR: begin
        // First cycle: the run mode is latched only now, so the switch
        // seen so far is stale; load the first leg and do not judge it
        if (first_reg) begin
          sel_next   = first_sel;
          dir_next   = first_dir;
          first_next = 1'b0;
          if (!first_leg_far) begin
            state_next = RSS_S_FAST;
          end
        end else if (sw_act) begin
          // Two-switch modes: far switch found, turn to the zero switch
          far_next   = pos;
          sel_next   = zero_right ? RSS_SW_RIGHT : RSS_SW_LEFT;
          dir_next   = zero_right;
          state_next = RSS_S_FAST;
        end
      end
      RSS_S_FAST: begin
        if (sw_act) begin
          a_next = pos;
          if (indexed) begin
            state_next = RSS_S_FINISH;
          end else if (both) begin
            state_next = RSS_S_CROSS;
          end else begin
            dir_next   = ~dir_reg;
            state_next = RSS_S_OUT;
          end
        end else if (lim_hit) begin
          dir_next = ~dir_reg;
        end
      end
      RSS_S_OUT: begin
        // Creep back until the switch releases
        if (!sw_act) begin
          a_next     = pos;
          dir_next   = ~dir_reg;
          state_next = RSS_S_IN;
        end
      end
      RSS_S_IN: begin
        // Re-enter from the other side
        if (sw_act) begin
          state_next = RSS_S_FINISH;
        end
      end
      RSS_S_CROSS: begin
        // Creep through until the far edge releases
        if (!sw_act) begin
          state_next = RSS_S_FINISH;
        end
      end
      RSS_S_FINISH: begin
        fin_now    = 1'b1;
        state_next = RSS_S_IDLE;
      end
      default: begin
        state_next = RSS_S_IDLE;
      end
    endcase
    if (cmd_start && new_valid) begin
      state_next = RSS_S_FAR;
      first_next = 1'b1;
    end
    if (cmd_stop) begin
      state_next = RSS_S_IDLE;
      fin_now    = 1'b0;
    end
  end

  // Zero point: index pulse position, otherwise the middle of two switching points
  wire [POS_W-1:0] zero_pos = indexed ? a_reg : mid_pos;

  // Sequencer state
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_reg    <= RSS_S_IDLE;
      sel_reg      <= RSS_SW_LEFT;
      dir_reg      <= 1'b0;
      first_reg    <= 1'b0;
      a_reg        <= '0;
      far_reg      <= '0;
      run_mode_reg <= RSS_MODE_RST;
    end else begin
      state_reg <= state_next;
      sel_reg   <= sel_next;
      dir_reg   <= dir_next;
      first_reg <= first_next;
      a_reg     <= a_next;
      far_reg   <= far_next;
      if (cmd_start && new_valid) begin
        run_mode_reg <= mode_reg;
      end
    end
  end

  // Start state resolves the first leg once the run mode is latched
  logic start_fix_reg;
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      start_fix_reg <= 1'b0;
    end else begin
      start_fix_reg <= cmd_start && new_valid && !cmd_stop;
    end
  end

  // Motion outputs, registered
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      run_reg      <= 1'b0;
      vel_fast_reg <= 1'b1;
    end else begin
      run_reg      <= (state_next != RSS_S_IDLE) && (state_next != RSS_S_FINISH);
      vel_fast_reg <= (state_next == RSS_S_FAR) || (state_next == RSS_S_FAST);
    end
  end

  assign RUN_O  = run_reg;
  assign DIR_O  = start_fix_reg ? first_dir : dir_reg;
  assign VEL_O  = vel_fast_reg ? vsrch_reg : vcreep_reg;
  assign BUSY_O = ~idle;

  // Completion pulse and zero point
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      zstb_reg <= 1'b0;
      zpos_reg <= '0;
    end else begin
      zstb_reg <= fin_now;
      if (fin_now) begin
        zpos_reg <= zero_pos;
      end
    end
  end
  assign ZERO_STB_O = zstb_reg;
  assign ZERO_POS_O = zpos_reg;

  // Software registers; completion clears encoder and, in two-switch modes, updates distance
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_reg    <= RSS_MODE_RST;
      vsrch_reg   <= RSS_VSRCH_RST;
      vcreep_reg  <= RSS_VCREEP_RST;
      stopcfg_reg <= 2'h0;
      dist_reg    <= 32'h0000_0000;
      enc_ofs_reg <= 32'h0000_0000;
      done_reg    <= 1'b0;
      err_reg     <= 1'b0;
    end else begin
      if (wr_en && PADDR_I == RSS_OFS_MODE)    mode_reg    <= PWDATA_I[7:0];
      if (wr_en && PADDR_I == RSS_OFS_VSRCH)   vsrch_reg   <= PWDATA_I;
      if (wr_en && PADDR_I == RSS_OFS_VCREEP)  vcreep_reg  <= PWDATA_I;
      if (wr_en && PADDR_I == RSS_OFS_STOPCFG) stopcfg_reg <= PWDATA_I[1:0];
      if (wr_en && PADDR_I == RSS_OFS_ENCPOS)  enc_ofs_reg <= ENC_CNT_I - PWDATA_I;
      if (cmd_start) begin
        done_reg <= 1'b0;
        err_reg  <= ~new_valid;
      end
      // Completion wins over a same-cycle encoder write
      if (fin_now) begin
        enc_ofs_reg <= ENC_CNT_I;
        done_reg    <= 1'b1;
        if (two_sw) begin
          dist_reg <= distance(far_reg, zero_pos);
        end
      end
    end
  end

  // Read data captured in the setup phase, valid through the access phase
  wire [31:0] status_w = {16'h0000, 1'b0, state_reg, 5'h00, err_reg, done_reg, ~idle};
  wire [31:0] rd_mux   = (PADDR_I == RSS_OFS_CMD)     ? {22'h0, RSS_ACT_QUERY, RSS_OPCODE} :
                         (PADDR_I == RSS_OFS_MODE)    ? {24'h0, mode_reg} :
                         (PADDR_I == RSS_OFS_VSRCH)   ? vsrch_reg :
                         (PADDR_I == RSS_OFS_VCREEP)  ? vcreep_reg :
                         (PADDR_I == RSS_OFS_DIST)    ? dist_reg :
                         (PADDR_I == RSS_OFS_STATUS)  ? status_w :
                         (PADDR_I == RSS_OFS_ENCPOS)  ? enc_pos :
                         (PADDR_I == RSS_OFS_STOPCFG) ? {30'h0, stopcfg_reg} : 32'h0000_0000;
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end
  assign PRDATA_O = prdata_reg;

endmodule

// ===== common/rss_pkg.sv
/*
  Package of the reference search sequencer: register map, field layout,
  mode encoding, command codes and state codes.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package rss_pkg;

  // Register byte offsets
  localparam logic [7:0] RSS_OFS_CMD     = 8'h00; // homing_command: opcode, action
  localparam logic [7:0] RSS_OFS_MODE    = 8'h04; // search mode
  localparam logic [7:0] RSS_OFS_VSRCH   = 8'h08; // search velocity
  localparam logic [7:0] RSS_OFS_VCREEP  = 8'h0C; // calibration velocity
  localparam logic [7:0] RSS_OFS_DIST    = 8'h10; // switch distance, read only
  localparam logic [7:0] RSS_OFS_STATUS  = 8'h14; // progress, read only
  localparam logic [7:0] RSS_OFS_ENCPOS  = 8'h18; // encoder position, read/write
  localparam logic [7:0] RSS_OFS_STOPCFG = 8'h1C; // end-switch auto stop enables

  // Command register fields
  localparam logic [7:0] RSS_OPCODE      = 8'h0D; // operation code 13
  localparam int         RSS_CMD_OP_LSB  = 0;
  localparam int         RSS_CMD_ACT_LSB = 8;
  localparam logic [1:0] RSS_ACT_START   = 2'h0;
  localparam logic [1:0] RSS_ACT_STOP    = 2'h1;
  localparam logic [1:0] RSS_ACT_QUERY   = 2'h2;

  // Mode field layout
  localparam int         RSS_MODE_SWAP_BIT = 6;       // plus 64: other side
  localparam int         RSS_MODE_INV_BIT  = 7;       // plus 128: home polarity
  localparam logic [5:0] RSS_MODE_BASE_MAX = 6'h0A;   // base modes 1 to 10

  // Status bits
  localparam int RSS_ST_BUSY = 0;
  localparam int RSS_ST_DONE = 1;
  localparam int RSS_ST_ERR  = 2;
  localparam int RSS_ST_STATE_LSB = 8;

  // Reset values
  localparam logic [7:0]  RSS_MODE_RST   = 8'h01;
  localparam logic [31:0] RSS_VSRCH_RST  = 32'h0000_1000;
  localparam logic [31:0] RSS_VCREEP_RST = 32'h0000_0100;

  // Switch selection codes
  typedef enum logic [1:0] {
    RSS_SW_LEFT  = 2'h0,
    RSS_SW_RIGHT = 2'h1,
    RSS_SW_HOME  = 2'h2,
    RSS_SW_INDEX = 2'h3
  } rss_sw_t;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    RSS_S_IDLE   = 7'h01,
    RSS_S_FAR    = 7'h02,
    RSS_S_FAST   = 7'h04,
    RSS_S_OUT    = 7'h08,
    RSS_S_IN     = 7'h10,
    RSS_S_CROSS  = 7'h20,
    RSS_S_FINISH = 7'h40
  } rss_state_t;

endpackage

// ===== test/rss_sequencer_chk.sv
/*
  Checker of the reference search sequencer: bus answer, start and stop,
  velocity choice and search direction.
  Assumes a bind into rss_sequencer; sees its ports only, dir high is positive.
*/
module rss_sequencer_chk
  import rss_pkg::*;
#(
  parameter int POS_W = 32
) (
  input wire logic             CLK_I,
  input wire logic             NRST_I,
  input wire logic             PSEL_I,
  input wire logic             PENABLE_I,
  input wire logic             PWRITE_I,
  input wire logic [7:0]       PADDR_I,
  input wire logic [31:0]      PWDATA_I,
  input wire logic [31:0]      PRDATA_O,
  input wire logic             PREADY_O,
  input wire logic             PSLVERR_O,
  input wire logic             LEFT_I,
  input wire logic             RIGHT_I,
  input wire logic             HOME_I,
  input wire logic             INDEX_I,
  input wire logic [POS_W-1:0] POS_I,
  input wire logic [31:0]      ENC_CNT_I,
  input wire logic             RUN_O,
  input wire logic             DIR_O,
  input wire logic [31:0]      VEL_O,
  input wire logic             ZERO_STB_O,
  input wire logic [POS_W-1:0] ZERO_POS_O,
  input wire logic             BUSY_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mode_q;
  logic [31:0] vsrch_q;
  logic [31:0] vcreep_q;
  logic        wr;
  logic        cmd_ok;
  logic        go;
  logic        halt;
  logic [5:0]  base;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  // Completed writes and homing commands as seen on the bus
  assign wr     = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  assign cmd_ok = wr && PADDR_I == RSS_OFS_CMD && PWDATA_I[7:0] == RSS_OPCODE;
  assign go     = cmd_ok && PWDATA_I[RSS_CMD_ACT_LSB +: 2] == RSS_ACT_START;
  assign halt   = cmd_ok && PWDATA_I[RSS_CMD_ACT_LSB +: 2] == RSS_ACT_STOP;
  assign base   = mode_q[5:0];

  // Shadow settings; a run may only use what software last wrote
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_q   <= RSS_MODE_RST;
      vsrch_q  <= RSS_VSRCH_RST;
      vcreep_q <= RSS_VCREEP_RST;
    end else if (wr) begin
      if (PADDR_I == RSS_OFS_MODE) mode_q <= PWDATA_I[7:0];
      if (PADDR_I == RSS_OFS_VSRCH) vsrch_q <= PWDATA_I;
      if (PADDR_I == RSS_OFS_VCREEP) vcreep_q <= PWDATA_I;
    end
  end

  a_apb_ready: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("bus access not answered at once");
  a_err_unmapped: assert property (PSEL_I && PENABLE_I &&
                                   (PADDR_I[1:0] != 2'h0 || PADDR_I > RSS_OFS_STOPCFG) |-> PSLVERR_O)
    else $error("unmapped access not flagged");
  a_start_busy: assert property (go && !BUSY_O |-> ##[1:4] BUSY_O)
    else $error("start command did not raise busy");
  a_stop_halt: assert property (halt |-> ##[1:8] (!BUSY_O && !RUN_O))
    else $error("stop command did not halt the axis");
  a_stop_no_zero: assert property (halt |-> ##1 (!ZERO_STB_O) [*8])
    else $error("zero point set after a stop");
  a_vel_legal: assert property (RUN_O |-> (VEL_O == vsrch_q || VEL_O == vcreep_q))
    else $error("velocity is neither search nor creep value");
  a_search_fast: assert property ($rose(BUSY_O) |-> ##[0:8] (RUN_O && VEL_O == vsrch_q))
    else $error("search did not start at search velocity");
  a_end_dir: assert property ($rose(BUSY_O) && base == 6'h01 |-> ##[0:8] (RUN_O && DIR_O == mode_q[6]))
    else $error("single end switch searched in wrong direction");
  a_left_turn: assert property (base == 6'h05 && RUN_O && !DIR_O && $rose(LEFT_I) |-> ##[1:8] DIR_O)
    else $error("no reversal at left limit");
  a_right_turn: assert property (base == 6'h06 && RUN_O && DIR_O && $rose(RIGHT_I) |-> ##[1:8] !DIR_O)
    else $error("no reversal at right limit");
  a_limits_ignored: assert property ((base == 6'h07 || base == 6'h08) && RUN_O && $stable(HOME_I) &&
                                     ($changed(LEFT_I) || $changed(RIGHT_I)) |-> ##1 $stable(DIR_O) [*3])
    else $error("limit switch changed direction while ignored");

  // Main scenarios reached
  c_stop: cover property (halt && BUSY_O);
  c_done: cover property ($fell(BUSY_O) && base == 6'h03);
  c_zero: cover property (ZERO_STB_O);
endmodule

// ===== test/rss_axis_model.sv
/*
  Slider model beside the reference search sequencer: two finite end
  switches, a movable home switch and an encoder index mark.
  Assumes one microstep per clock while run is high, dir high positive.
*/
module rss_axis_model (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               load_i,
  input  wire logic               run_i,
  input  wire logic               dir_i,
  input  wire logic signed [31:0] home_lo_i,
  input  wire logic signed [31:0] home_hi_i,
  input  wire logic               home_inv_i,
  output logic                    left_o,
  output logic                    right_o,
  output logic                    home_o,
  output logic                    index_o,
  output logic             [31:0] pos_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LEFT_LO  = -120;
  localparam int LEFT_HI  = -100;
  localparam int RIGHT_LO = 100;
  localparam int RIGHT_HI = 120;
  int pos;

  // Slider position; load parks it at the origin between runs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos <= 0;
    end else if (load_i) begin
      pos <= 0;
    end else if (run_i) begin
      pos <= dir_i ? pos + 1 : pos - 1;
    end
  end

  // Finite switches, so that both edges of each can be found
  assign left_o  = pos >= LEFT_LO && pos <= LEFT_HI;
  assign right_o = pos >= RIGHT_LO && pos <= RIGHT_HI;
  assign home_o  = (pos >= home_lo_i && pos <= home_hi_i) ^ home_inv_i;
  assign index_o = (pos & 63) == 32; // Narrow mark, active high as configured
  assign pos_o   = pos;
endmodule

// ===== test/tb_rss_sequencer.sv
/*
  Testbench of the reference search sequencer: registers over APB, 16 of
  the 18 valid search modes against the slider model, query and stop.
  Assumes rss_pkg, rss_axis_model and rss_sequencer_chk compiled first.
*/
module tb_rss_sequencer
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, nrst, psel, penable, pwrite, load, home_inv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pos, vel, zpos, q, v;
  logic        pready, sw_left, sw_right, sw_home, sw_index, run, dir, zstb, busy;
  int          home_lo, home_hi, miscompares, comparisons, zcnt, zseen, seed;
  // Mode, home window, home inverted, zero window, switch distance (0: none)
  int tbl[16][7] = '{
    '{1, 999, 999, 0, -102, -98, 0}, '{65, 999, 999, 0, 98, 102, 0},
    '{2, 999, 999, 0, -102, -98, 200}, '{66, 999, 999, 0, 98, 102, 200},
    '{3, 999, 999, 0, -113, -107, 210}, '{67, 999, 999, 0, 107, 113, 210},
    '{4, 999, 999, 0, -113, -107, 0}, '{68, 999, 999, 0, 107, 113, 0},
    '{5, 40, 60, 0, 38, 62, 0}, '{133, 40, 60, 1, 38, 62, 0},
    '{6, -60, -40, 0, -62, -38, 0}, '{7, -160, -140, 0, -152, -148, 0},
    '{8, 140, 160, 0, 148, 152, 0}, '{136, 140, 160, 1, 148, 152, 0},
    '{9, 999, 999, 0, 30, 34, 0}, '{10, 999, 999, 0, -34, -30, 0}};

  rss_sequencer #(.POS_W(32)) rss_sequencer_inst (
    .CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(),
    .LEFT_I(sw_left), .RIGHT_I(sw_right), .HOME_I(sw_home), .INDEX_I(sw_index), .POS_I(pos),
    .ENC_CNT_I(pos), .RUN_O(run), .DIR_O(dir), .VEL_O(vel), .ZERO_STB_O(zstb),
    .ZERO_POS_O(zpos), .BUSY_O(busy));
  rss_axis_model rss_axis_model_inst (
    .clk_i(clk), .nrst_i(nrst), .load_i(load), .run_i(run), .dir_i(dir), .home_lo_i(home_lo),
    .home_hi_i(home_hi), .home_inv_i(home_inv), .left_o(sw_left), .right_o(sw_right),
    .home_o(sw_home), .index_o(sw_index), .pos_o(pos));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Every zero-point strobe, sampled mid-cycle where it is settled
  always @(negedge clk) begin
    if (zstb === 1'b1) begin
      zcnt++;
      zseen = $signed(zpos);
    end
  end

  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; an edge always passes first, so calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0, q);
    check(nm, q, exp);
  endtask

  function automatic logic [31:0] cmd(input logic [1:0] act);
    return (32'(act) << RSS_CMD_ACT_LSB) | (32'(RSS_OPCODE) << RSS_CMD_OP_LSB);
  endfunction

  // Bounded wait on busy; a hang ends the run as a mismatch
  task automatic wait_busy(input logic b);
    int n;
    n = 0;
    while (busy !== b && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (busy !== b) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // Park the slider, run one mode from the table, judge the outcome
  task automatic home_run(input int r);
    home_lo  <= tbl[r][1];
    home_hi  <= tbl[r][2];
    home_inv <= tbl[r][3][0];
    load     <= 1'b1;
    wr_reg(RSS_OFS_MODE, 32'(tbl[r][0]));
    load     <= 1'b0;
    wr_reg(RSS_OFS_ENCPOS, 32'h0000_1234);
    rd(RSS_OFS_ENCPOS, 32'h0000_1234, "enc_written");
    zcnt = 0;
    wr_reg(RSS_OFS_CMD, cmd(RSS_ACT_START));
    wait_busy(1'b1);
    wr_reg(RSS_OFS_CMD, cmd(RSS_ACT_QUERY));
    apb(1'b0, RSS_OFS_STATUS, 32'h0, q);
    check("status_busy", 32'(q[RSS_ST_BUSY]), 32'h1);
    wait_busy(1'b0);
    repeat (2) @(posedge clk); // Strobe rises in the same cycle that busy falls
    check("zero_count", zcnt, 32'h1);
    check("zero_window", 32'(zseen >= tbl[r][4] && zseen <= tbl[r][5]), 32'h1);
    if (tbl[r][6] > 0) begin
      apb(1'b0, RSS_OFS_DIST, 32'h0, q);
      check("distance", 32'(int'(q) >= tbl[r][6] - 3 && int'(q) <= tbl[r][6] + 3), 32'h1);
    end
    rd(RSS_OFS_ENCPOS, 32'h0, "enc_cleared");
  endtask

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, home_inv} = '0;
    load = 1'b1;
    home_lo = 999;
    home_hi = 999;
    {miscompares, comparisons, zcnt, zseen} = '0;
    seed = 32'h67468E40;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    load <= 1'b0;
    rd(RSS_OFS_MODE, {24'h0, RSS_MODE_RST}, "mode_reset");
    rd(RSS_OFS_VSRCH, RSS_VSRCH_RST, "vsrch_reset");
    rd(RSS_OFS_VCREEP, RSS_VCREEP_RST, "vcreep_reset");
    apb(1'b0, RSS_OFS_DIST, 32'h0, v);
    wr_reg(RSS_OFS_DIST, ~v);
    rd(RSS_OFS_DIST, v, "dist_read_only");
    wr_reg(8'h20, $random(seed));
    rd(RSS_OFS_MODE, {24'h0, RSS_MODE_RST}, "unmapped_write");
    v = ($random(seed) & 32'h0000_FFFF) | 32'h1;
    wr_reg(RSS_OFS_VSRCH, v);
    rd(RSS_OFS_VSRCH, v, "vsrch_rw");
    v = ($random(seed) & 32'h0000_0FFF) | 32'h1;
    wr_reg(RSS_OFS_VCREEP, v);
    rd(RSS_OFS_VCREEP, v, "vcreep_rw");
    wr_reg(RSS_OFS_STOPCFG, 32'h0000_0003); // Auto stops on, homing must not care
    for (int i = 0; i < 16; i++) begin
      home_run(i);
    end
    // Stop in mid-search: nothing reported, distance kept
    apb(1'b0, RSS_OFS_DIST, 32'h0, v);
    load <= 1'b1;
    wr_reg(RSS_OFS_MODE, 32'h0000_0002);
    load <= 1'b0;
    zcnt = 0;
    wr_reg(RSS_OFS_CMD, cmd(RSS_ACT_START));
    repeat (30) @(posedge clk);
    wr_reg(RSS_OFS_CMD, cmd(RSS_ACT_STOP));
    wait_busy(1'b0);
    repeat (2) @(posedge clk); // A late strobe would show here
    check("stop_zero", zcnt, 32'h0);
    rd(RSS_OFS_DIST, v, "stop_dist");
    wrap_up();
  end
endmodule

bind rss_sequencer rss_sequencer_chk #(.POS_W(POS_W)) rss_sequencer_chk_inst (.*);
